// *** hdl/sgp_regs.sv ***
// Port-five link, null VID and storm rate register bank
`default_nettype none
module sgp_regs #(
  parameter int PERIOD_100_CYC = sgp_pkg::SGP_PERIOD_100_CYC,
  parameter int PERIOD_10_CYC  = sgp_pkg::SGP_PERIOD_10_CYC
) (
  input  wire logic                           clock,
  input  wire logic                           nrst,
  input  wire logic [7:0]                     addr,
  input  wire logic [7:0]                     wdata,
  input  wire logic                           wr_stb,
  input  wire logic                           rd_stb,
  output logic      [7:0]                     rdata,
  input  wire logic                           duplex_strap_pin,
  input  wire logic                           flow_ctrl_strap_pin,
  input  wire logic                           speed_strap_pin,
  input  wire logic                           bcast_block_seen,
  input  wire logic                           vid_valid,
  input  wire logic [sgp_pkg::SGP_VID_W-1:0]  ingress_vid,
  input  wire logic [sgp_pkg::SGP_VID_W-1:0]  port_vid,
  output logic                                egress_vid_valid,
  output logic      [sgp_pkg::SGP_VID_W-1:0]  egress_vid,
  output logic                                p5_half_duplex,
  output logic                                p5_flow_ctrl_en,
  output logic                                p5_speed_10m,
  output logic                                null_vid_replace_en,
  output logic      [sgp_pkg::SGP_RATE_W-1:0] storm_rate,
  output logic                                storm_limit
);
  import sgp_pkg::*;

  typedef struct packed {
    logic                 half_duplex;
    logic                 flow_en;
    logic                 speed_10m;
    logic                 null_vid;
    logic [2:0]           storm_hi;
    logic [7:0]           storm_lo;
    logic [7:0]           rdata;
    logic                 vid_valid;
    logic [SGP_VID_W-1:0] vid;
  } sgp_regs_st_t;

  sgp_regs_st_t st_r;
  sgp_regs_st_t st_nxt;
  logic         cap_stb;

  // Port-five control register image
  function automatic logic [7:0] p5_ctrl_image(input sgp_regs_st_t s);
    logic [7:0] v;
    v = 8'h00;
    v[SGP_BIT_HALF_DUPLEX] = s.half_duplex;
    v[SGP_BIT_FLOW_CTRL]   = s.flow_en;
    v[SGP_BIT_SPEED_10M]   = s.speed_10m;
    v[SGP_BIT_NULL_VID]    = s.null_vid;
    v[SGP_STORM_HI_MSB:0]  = s.storm_hi;
    return v;
  endfunction

  // Read multiplexer; unmapped offsets read zero
  function automatic logic [7:0] read_mux(input logic [7:0] a, input sgp_regs_st_t s);
    logic [7:0] v;
    v = SGP_UNMAPPED_VAL;
    case (a)
      SGP_ADDR_P5_CTRL:   v = p5_ctrl_image(s);
      SGP_ADDR_STORM_LO:  v = s.storm_lo;
      SGP_ADDR_FACT_A:    v = SGP_FACT_A_VAL;
      SGP_ADDR_FACT_B:    v = SGP_FACT_B_VAL;
      SGP_ADDR_FACT_C:    v = SGP_FACT_C_VAL;
      SGP_ADDR_CTRL_NINE: v = SGP_NINE_VAL;
      default:            v = SGP_UNMAPPED_VAL;
    endcase
    return v;
  endfunction

  // Strap strobe in the first cycle after reset release
  sgp_strap_capture i_sgp_strap_capture (
    .clock   (clock),
    .nrst    (nrst),
    .cap_stb (cap_stb)
  );

  // Storm meter for the fifth switch port
  sgp_storm_meter #(
    .PERIOD_100_CYC (PERIOD_100_CYC),
    .PERIOD_10_CYC  (PERIOD_10_CYC)
  ) i_sgp_storm_meter (
    .clock       (clock),
    .nrst        (nrst),
    .speed_10m   (st_r.speed_10m),
    .rate        ({st_r.storm_hi, st_r.storm_lo}),
    .block_seen  (bcast_block_seen),
    .storm_limit (storm_limit)
  );

  // Next-state: strap load, register writes, read data, VID path
  always_comb begin
    st_nxt = st_r;
    if (cap_stb) begin
      st_nxt.half_duplex = duplex_strap_pin;
      st_nxt.flow_en     = flow_ctrl_strap_pin;
      st_nxt.speed_10m   = speed_strap_pin;
    end
    // A write in the capture cycle still wins
    if (wr_stb) begin
      case (addr)
        SGP_ADDR_P5_CTRL: begin
          st_nxt.half_duplex = wdata[SGP_BIT_HALF_DUPLEX];
          st_nxt.flow_en     = wdata[SGP_BIT_FLOW_CTRL];
          st_nxt.speed_10m   = wdata[SGP_BIT_SPEED_10M];
          st_nxt.null_vid    = wdata[SGP_BIT_NULL_VID];
          st_nxt.storm_hi    = wdata[SGP_STORM_HI_MSB:0];
        end
        SGP_ADDR_STORM_LO: begin
          st_nxt.storm_lo = wdata;
        end
        default: begin
          st_nxt.storm_lo = st_r.storm_lo; // Read-only and unmapped writes dropped
        end
      endcase
    end
    // Read data stands only in the cycle after the strobe
    st_nxt.rdata = rd_stb ? read_mux(addr, st_r) : 8'h00;
    // Null VID replacement
    st_nxt.vid_valid = vid_valid;
    if (st_r.null_vid && ingress_vid == '0) begin
      st_nxt.vid = port_vid;
    end else begin
      st_nxt.vid = ingress_vid;
    end
  end

  // State register; straps default to the pull-down level
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      st_r             <= '0;
      st_r.half_duplex <= SGP_STRAP_PD;
      st_r.flow_en     <= SGP_STRAP_PD;
      st_r.speed_10m   <= SGP_STRAP_PD;
      st_r.null_vid    <= SGP_NULL_VID_RST;
      st_r.storm_hi    <= SGP_STORM_HI_RST;
      st_r.storm_lo    <= SGP_STORM_LO_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs straight from flops
  assign rdata               = st_r.rdata;
  assign p5_half_duplex      = st_r.half_duplex;
  assign p5_flow_ctrl_en     = st_r.flow_en;
  assign p5_speed_10m        = st_r.speed_10m;
  assign null_vid_replace_en = st_r.null_vid;
  assign storm_rate          = {st_r.storm_hi, st_r.storm_lo};
  assign egress_vid_valid    = st_r.vid_valid;
  assign egress_vid          = st_r.vid;

  // Helper: storm rate untouched by software since reset
  logic storm_written_r;
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      storm_written_r <= 1'b0;
    end else if (wr_stb && (addr == SGP_ADDR_P5_CTRL || addr == SGP_ADDR_STORM_LO)) begin
      storm_written_r <= 1'b1;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);

  a_half_duplex_write: assert property (wr_stb && addr == SGP_ADDR_P5_CTRL |=>
    p5_half_duplex == $past(wdata[SGP_BIT_HALF_DUPLEX])) else $error("half duplex write lost");
  a_flow_ctrl_write: assert property (wr_stb && addr == SGP_ADDR_P5_CTRL |=>
    p5_flow_ctrl_en == $past(wdata[SGP_BIT_FLOW_CTRL])) else $error("flow control write lost");
  a_speed_write: assert property (wr_stb && addr == SGP_ADDR_P5_CTRL |=>
    p5_speed_10m == $past(wdata[SGP_BIT_SPEED_10M])) else $error("speed write lost");
  a_strap_load: assert property (cap_stb && !wr_stb |=> p5_half_duplex == $past(duplex_strap_pin)
    && p5_flow_ctrl_en == $past(flow_ctrl_strap_pin) && p5_speed_10m == $past(speed_strap_pin))
    else $error("strap values not loaded");
  a_strap_hold: assert property (!cap_stb && !wr_stb |=> $stable(p5_half_duplex) && $stable(p5_speed_10m))
    else $error("link bits changed without write");
  a_flow_strap_hold: assert property (!cap_stb && !wr_stb |=> $stable(p5_flow_ctrl_en))
    else $error("flow bit changed without write");
  a_null_vid_swap: assert property (null_vid_replace_en && ingress_vid == '0 |=>
    egress_vid == $past(port_vid)) else $error("null VID not replaced");
  a_vid_pass: assert property (!null_vid_replace_en |=> egress_vid == $past(ingress_vid))
    else $error("VID altered while disabled");
  a_storm_join: assert property (wr_stb && addr == SGP_ADDR_P5_CTRL |=>
    storm_rate[SGP_RATE_W-1:8] == $past(wdata[SGP_STORM_HI_MSB:0])) else $error("storm high bits wrong");
  a_storm_default: assert property (!storm_written_r |-> storm_rate == {SGP_STORM_HI_RST, SGP_STORM_LO_RST})
    else $error("storm rate default wrong");
  a_factory_read: assert property (rd_stb && addr == SGP_ADDR_FACT_B |=> rdata == SGP_FACT_B_VAL)
    else $error("factory register value wrong");
  a_read_window: assert property (!rd_stb |=> rdata == 8'h00) else $error("read data outside window");

  c_p5_write: cover property (wr_stb && addr == SGP_ADDR_P5_CTRL ##1 rd_stb && addr == SGP_ADDR_P5_CTRL);
  c_vid_swap: cover property (vid_valid && null_vid_replace_en && ingress_vid == '0);
  c_storm_low: cover property (wr_stb && addr == SGP_ADDR_STORM_LO);
endmodule
`default_nettype wire

// *** hdl/sgp_pkg.sv ***
// Constants shared by the port-five and storm-control register bank
`default_nettype none
package sgp_pkg;
  // Register offsets
  localparam logic [7:0] SGP_ADDR_P5_CTRL   = 8'h06;
  localparam logic [7:0] SGP_ADDR_STORM_LO  = 8'h07;
  localparam logic [7:0] SGP_ADDR_FACT_A    = 8'h08;
  localparam logic [7:0] SGP_ADDR_FACT_B    = 8'h09;
  localparam logic [7:0] SGP_ADDR_FACT_C    = 8'h0A;
  localparam logic [7:0] SGP_ADDR_CTRL_NINE = 8'h0B;
  // Field positions in the port-five control register
  localparam int SGP_BIT_HALF_DUPLEX = 6;
  localparam int SGP_BIT_FLOW_CTRL   = 5;
  localparam int SGP_BIT_SPEED_10M   = 4;
  localparam int SGP_BIT_NULL_VID    = 3;
  localparam int SGP_STORM_HI_MSB    = 2;
  // Widths
  localparam int SGP_RATE_W = 11;
  localparam int SGP_VID_W  = 12;
  localparam int SGP_PER_W  = 23;
  // Reset and fixed read values
  localparam logic [7:0] SGP_STORM_LO_RST = 8'h4A;
  localparam logic [2:0] SGP_STORM_HI_RST = 3'h0;
  localparam logic       SGP_NULL_VID_RST = 1'h0;
  localparam logic       SGP_STRAP_PD     = 1'h0;
  localparam logic [7:0] SGP_FACT_A_VAL   = 8'h00;
  localparam logic [7:0] SGP_FACT_B_VAL   = 8'h4C;
  localparam logic [7:0] SGP_FACT_C_VAL   = 8'h00;
  localparam logic [7:0] SGP_NINE_VAL     = 8'h00;
  localparam logic [7:0] SGP_UNMAPPED_VAL = 8'h00;
  // Storm measurement periods
  localparam int SGP_CLK_HZ        = 10_000_000;
  localparam int SGP_PERIOD_100_MS = 50;
  localparam int SGP_PERIOD_10_MS  = 500;
  localparam int SGP_PERIOD_100_CYC = (SGP_CLK_HZ / 1000) * SGP_PERIOD_100_MS;
  localparam int SGP_PERIOD_10_CYC  = (SGP_CLK_HZ / 1000) * SGP_PERIOD_10_MS;
endpackage
`default_nettype wire

// *** hdl/sgp_strap_capture.sv ***
// One-shot strap capture strobe after reset release
`default_nettype none
module sgp_strap_capture (
  input  wire logic clock,
  input  wire logic nrst,
  output logic      cap_stb
);
  import sgp_pkg::*;

  typedef struct packed {
    logic done;
  } sgp_strap_st_t;

  sgp_strap_st_t st_r;
  sgp_strap_st_t st_nxt;

  // Mark capture done after the first edge past release
  always_comb begin
    st_nxt      = st_r;
    st_nxt.done = 1'b1;
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // High while reset is asserted and in the first cycle after release
  assign cap_stb = !st_r.done;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);

  a_strap_once: assert property (cap_stb |=> !cap_stb [*3]) else $error("strap strobe repeated");
endmodule
`default_nettype wire

// *** hdl/sgp_storm_meter.sv ***
// Broadcast storm meter: 64-byte blocks per period against the rate
`default_nettype none
module sgp_storm_meter #(
  parameter int PERIOD_100_CYC = sgp_pkg::SGP_PERIOD_100_CYC,
  parameter int PERIOD_10_CYC  = sgp_pkg::SGP_PERIOD_10_CYC
) (
  input  wire logic                          clock,
  input  wire logic                          nrst,
  input  wire logic                          speed_10m,
  input  wire logic [sgp_pkg::SGP_RATE_W-1:0] rate,
  input  wire logic                          block_seen,
  output logic                               storm_limit
);
  import sgp_pkg::*;

  localparam logic [SGP_PER_W-1:0] LAST_100 = SGP_PER_W'(PERIOD_100_CYC - 1);
  localparam logic [SGP_PER_W-1:0] LAST_10  = SGP_PER_W'(PERIOD_10_CYC - 1);

  typedef struct packed {
    logic [SGP_PER_W-1:0]  per_cnt;
    logic [SGP_RATE_W-1:0] blk_cnt;
    logic                  speed;
    logic                  limit;
  } sgp_storm_st_t;

  sgp_storm_st_t st_r;
  sgp_storm_st_t st_nxt;
  logic          period_end;
  logic [SGP_PER_W-1:0] last_cnt;

  // Period length follows the port speed
  assign last_cnt   = st_r.speed ? LAST_10 : LAST_100;
  assign period_end = (st_r.per_cnt >= last_cnt) || (st_r.speed != speed_10m);

  // Count time and accepted blocks, restart at period end
  always_comb begin
    st_nxt       = st_r;
    st_nxt.speed = speed_10m;
    if (period_end) begin
      st_nxt.per_cnt = '0;
      st_nxt.blk_cnt = '0;
    end else begin
      st_nxt.per_cnt = st_r.per_cnt + 1'b1;
      if (block_seen && st_r.blk_cnt < rate) begin
        st_nxt.blk_cnt = st_r.blk_cnt + 1'b1;
      end
    end
    st_nxt.limit = (st_nxt.blk_cnt >= rate);
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign storm_limit = st_r.limit;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);

  a_period_bound: assert property (st_r.per_cnt <= (st_r.speed ? LAST_10 : LAST_100))
    else $error("storm period overrun");
  a_blocks_capped: assert property (st_r.blk_cnt <= rate || $changed(rate))
    else $error("storm block count above rate");
  c_storm_hit: cover property ($rose(storm_limit));
endmodule
`default_nettype wire

// *** tb/sgp_regs_tb.sv ***
// Self-checking bench for the port-five link and storm rate register bank
`default_nettype none
module sgp_regs_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import sgp_pkg::*;

  // Short storm periods keep the run brief
  localparam int P100 = 20;
  localparam int P10  = 50;

  logic                  clock;
  logic                  nrst;
  logic [7:0]            addr;
  logic [7:0]            wdata;
  logic                  wr_stb;
  logic                  rd_stb;
  logic [7:0]            rdata;
  logic                  duplex_strap_pin;
  logic                  flow_ctrl_strap_pin;
  logic                  speed_strap_pin;
  logic                  bcast_block_seen;
  logic                  vid_valid;
  logic [SGP_VID_W-1:0]  ingress_vid;
  logic [SGP_VID_W-1:0]  port_vid;
  logic                  egress_vid_valid;
  logic [SGP_VID_W-1:0]  egress_vid;
  logic                  p5_half_duplex;
  logic                  p5_flow_ctrl_en;
  logic                  p5_speed_10m;
  logic                  null_vid_replace_en;
  logic [SGP_RATE_W-1:0] storm_rate;
  logic                  storm_limit;
  int                    n_fail;
  int                    checks_done;
  int                    cycles;

  sgp_regs #(.PERIOD_100_CYC(P100), .PERIOD_10_CYC(P10)) i_sgp_regs (
    .clock(clock), .nrst(nrst), .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb),
    .rdata(rdata), .duplex_strap_pin(duplex_strap_pin), .flow_ctrl_strap_pin(flow_ctrl_strap_pin),
    .speed_strap_pin(speed_strap_pin), .bcast_block_seen(bcast_block_seen), .vid_valid(vid_valid),
    .ingress_vid(ingress_vid), .port_vid(port_vid), .egress_vid_valid(egress_vid_valid),
    .egress_vid(egress_vid), .p5_half_duplex(p5_half_duplex), .p5_flow_ctrl_en(p5_flow_ctrl_en),
    .p5_speed_10m(p5_speed_10m), .null_vid_replace_en(null_vid_replace_en), .storm_rate(storm_rate),
    .storm_limit(storm_limit)
  );

  // 100 ns clock
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  // Hang guard
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      n_fail++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    $display("checks=%0d mismatches=%0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One-cycle write, outputs looked at once it lands
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    addr   <= a;
    wdata  <= d;
    wr_stb <= 1'b1;
    @(posedge clock);
    wr_stb <= 1'b0;
    @(negedge clock);
  endtask

  // One-cycle read, data taken in the following cycle only
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clock);
    addr   <= a;
    rd_stb <= 1'b1;
    @(posedge clock);
    rd_stb <= 1'b0;
    @(negedge clock);
    chk(rdata, exp);
  endtask

  task automatic do_reset(input logic d, input logic f, input logic s);
    @(posedge clock);
    nrst                <= 1'b0;
    duplex_strap_pin    <= d;
    flow_ctrl_strap_pin <= f;
    speed_strap_pin     <= s;
    repeat (10) @(posedge clock);
    nrst <= 1'b1;
    repeat (2) @(posedge clock);
    @(negedge clock);
  endtask

  task automatic vid(input logic [11:0] ing, input logic [11:0] pv, input logic [11:0] exp);
    @(posedge clock);
    vid_valid   <= 1'b1;
    ingress_vid <= ing;
    port_vid    <= pv;
    @(posedge clock);
    vid_valid <= 1'b0;
    @(negedge clock);
    chk({egress_vid_valid, egress_vid}, {1'b1, exp});
  endtask

  // Two blocks reach a rate of two; measure how long the limit holds
  task automatic storm(input int lo, input int hi);
    int n;
    n = 0;
    @(posedge clock);
    bcast_block_seen <= 1'b1;
    repeat (2) @(posedge clock);
    bcast_block_seen <= 1'b0;
    @(posedge clock);
    @(negedge clock);
    chk(storm_limit, 1'b1);
    while (storm_limit === 1'b1 && n < 200) begin
      @(negedge clock);
      n++;
    end
    chk(n >= lo && n <= hi, 1'b1);
  endtask

  // Main sequence
  initial begin
    nrst = 1'b0; addr = 8'h00; wdata = 8'h00; wr_stb = 1'b0; rd_stb = 1'b0;
    duplex_strap_pin = 1'b0; flow_ctrl_strap_pin = 1'b0; speed_strap_pin = 1'b0;
    bcast_block_seen = 1'b0; vid_valid = 1'b0; ingress_vid = 12'h000; port_vid = 12'h000;
    n_fail = 0; checks_done = 0; cycles = 0;
    do_reset(1'b1, 1'b0, 1'b1);
    chk({p5_half_duplex, p5_flow_ctrl_en, p5_speed_10m}, 3'b101);
    chk(storm_rate, 11'h04A);
    rd(SGP_ADDR_P5_CTRL, 8'h50);
    rd(SGP_ADDR_STORM_LO, 8'h4A);
    duplex_strap_pin <= 1'b0;
    speed_strap_pin  <= 1'b0;
    repeat (3) @(negedge clock);
    chk({p5_half_duplex, p5_flow_ctrl_en, p5_speed_10m}, 3'b101);
    do_reset(1'b0, 1'b1, 1'b0);
    chk({p5_half_duplex, p5_flow_ctrl_en, p5_speed_10m}, 3'b010);
    rd(SGP_ADDR_P5_CTRL, 8'h20);
    wr(SGP_ADDR_P5_CTRL, 8'h78);
    chk({p5_half_duplex, p5_flow_ctrl_en, p5_speed_10m, null_vid_replace_en}, 4'hF);
    rd(SGP_ADDR_P5_CTRL, 8'h78);
    wr(SGP_ADDR_P5_CTRL, 8'h85);
    wr(SGP_ADDR_STORM_LO, 8'hC3);
    chk(storm_rate, 11'h5C3);
    chk({p5_half_duplex, p5_flow_ctrl_en, p5_speed_10m, null_vid_replace_en}, 4'h0);
    rd(SGP_ADDR_P5_CTRL, 8'h05);
    // Fixed test registers ignore writes
    wr(SGP_ADDR_FACT_B, 8'hFF);
    rd(SGP_ADDR_FACT_A, 8'h00);
    rd(SGP_ADDR_FACT_B, 8'h4C);
    rd(SGP_ADDR_FACT_C, 8'h00);
    rd(8'h20, 8'h00);
    // Null VID substitution on and off
    wr(SGP_ADDR_P5_CTRL, 8'h08);
    vid(12'h000, 12'h123, 12'h123);
    vid(12'h055, 12'h123, 12'h055);
    wr(SGP_ADDR_P5_CTRL, 8'h00);
    vid(12'h000, 12'h123, 12'h000);
    // Storm period at each speed
    wr(SGP_ADDR_STORM_LO, 8'h02);
    wr(SGP_ADDR_P5_CTRL, 8'h10);
    storm(P10 - 8, P10);
    wr(SGP_ADDR_P5_CTRL, 8'h00);
    storm(P100 - 8, P100);
    print_verdict();
  end
endmodule
`default_nettype wire
